/* design/stog_params.svh */
// Constants of the safe torque off gate
`ifndef STOG_PARAMS_SVH
`define STOG_PARAMS_SVH
// Self-check pulse length (ns) and derived cycle count at 25 MHz
`define STOG_CLK_NS        40
`define STOG_CHECK_NS      2000
`define STOG_CHECK_CYC     ((`STOG_CHECK_NS + `STOG_CLK_NS - 1) / `STOG_CLK_NS)
// Check ends after the pulse phase and an equal quiet phase
`define STOG_CHECK_END     (2 * `STOG_CHECK_CYC)
`define STOG_CNT_W         8
`define STOG_CNT_ZERO      8'h00
`define STOG_CNT_ONE       8'h01
`endif

/* design/stog_pkg.sv */
// Types of the safe torque off gate
package stog_pkg;
  // Gate sequencing states
  typedef enum logic [1:0] {
    stog_off,
    stog_check,
    stog_run,
    stog_failed
  } stog_state_t;
endpackage

/* design/stog_gate.sv */
// Safe torque off gate: redundant input pair, self-check and drive enable
// Operation
// - Enabled feature turns inputs one, two into safety
// - Drive allowed only with both inputs high
// - Self-check at power-on before drive, except one drive cycle after reset while the jumper still reads fitted
// - Repeat self-check on entry into both-high
// - Either input low disables outputs immediately
// - Single input high flags fault; both low not
// - Feature enabled only when jumper removed
// - Only remove drive, never brake actively
`include "stog_params.svh"
module stog_gate
  import stog_pkg::*;
(
  // Clock and reset
  input  wire logic clock,
  input  wire logic rstn,
  // Pins
  input  wire logic digital_input_one,
  input  wire logic digital_input_two,
  input  wire logic jumper_fitted,
  // Self-check loop: test pulse out, readback in
  output logic      check_drive,
  input  wire logic check_readback,
  // Results
  output logic      drive_enable,
  output logic      brake_request,
  output logic      fault,
  output logic      feature_active,
  output logic      general_input_one,
  output logic      general_input_two
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [1:0]             sync_a1;   // First stage, inputs a/b
    logic [1:0]             sync_a2;   // Second stage
    logic                   sync_j1;
    logic                   sync_j2;
    logic                   sync_r1;
    logic                   sync_r2;
    logic                   both_prev;  // Both-high seen last cycle
    stog_state_t            state;
    logic [`STOG_CNT_W-1:0] count;     // Self-check timer
    logic                   pulse;     // Test pulse being driven
    logic [1:0]             pulse_d;   // Pulse delayed to line up with synced readback
    logic                   check_bad; // Readback mismatch seen
    logic                   enable;
    logic                   fault;
  } stog_reg_t;

  stog_reg_t cur;
  stog_reg_t next_cur;

  logic torque_off_input_a;  // Safety input views
  logic torque_off_input_b;
  logic active;
  logic both_high;

  // Combinational reading of synchronised pins
  always_comb begin
    torque_off_input_a = cur.sync_a2[0];
    torque_off_input_b = cur.sync_a2[1];
    active             = ~cur.sync_j2;
    both_high          = torque_off_input_a & torque_off_input_b;
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_cur           = cur;
    next_cur.sync_a1   = {digital_input_two, digital_input_one};
    next_cur.sync_a2   = cur.sync_a1;
    next_cur.sync_j1   = jumper_fitted;
    next_cur.sync_j2   = cur.sync_j1;
    next_cur.sync_r1   = check_readback;
    next_cur.sync_r2   = cur.sync_r1;
    next_cur.both_prev = both_high;
    // Readback passes two sync flops, so compare against a two-cycle copy
    next_cur.pulse_d   = {cur.pulse_d[0], cur.pulse};
    // Mismatch between channels is a fault; both low is a plain stop
    next_cur.fault     = cur.fault;
    if (!active) begin
      // Feature off: gate never blocks drive
      next_cur.state  = stog_off;
      next_cur.enable = 1'b1;
      next_cur.fault  = 1'b0;
      next_cur.pulse  = 1'b0;
    end else begin
      case (cur.state)
        stog_off: begin
          // Power-on or new both-high entry starts a
          next_cur.enable = 1'b0;
          next_cur.fault  = torque_off_input_a ^ torque_off_input_b;
          if (both_high && (!cur.both_prev || !cur.enable)) begin
            next_cur.state     = stog_check;
            next_cur.count     = `STOG_CNT_ZERO;
            next_cur.pulse     = 1'b1;
            next_cur.check_bad = 1'b0;
          end
        end
        stog_check: begin
          // Readback must follow the pulse; compared after settling
          next_cur.enable = 1'b0;
          next_cur.count  = cur.count + `STOG_CNT_ONE;
          if (cur.count > `STOG_CNT_ONE && cur.sync_r2 != cur.pulse_d[1]) begin
            next_cur.check_bad = 1'b1;
          end
          if (cur.count == (`STOG_CNT_W)'(`STOG_CHECK_CYC)) begin
            next_cur.pulse = 1'b0;
          end
          if (!both_high) begin
            next_cur.state = stog_off;
            next_cur.pulse = 1'b0;
            next_cur.fault = torque_off_input_a ^ torque_off_input_b;
          end else if (cur.count == (`STOG_CNT_W)'(`STOG_CHECK_END)) begin
            if (cur.check_bad) begin
              next_cur.state = stog_failed;
              next_cur.fault = 1'b1;
            end else begin
              next_cur.state  = stog_run;
              next_cur.enable = 1'b1;
              next_cur.fault  = 1'b0;
            end
          end
        end
        stog_run: begin
          // Any low input leaves run and clears the enable register on the next edge
          if (!both_high) begin
            next_cur.state  = stog_off;
            next_cur.enable = 1'b0;
            next_cur.fault  = torque_off_input_a ^ torque_off_input_b;
          end
        end
        stog_failed: begin
          // Held off with fault until either input drops
          next_cur.enable = 1'b0;
          next_cur.fault  = 1'b1;
          if (!both_high) begin
            next_cur.state = stog_off;
          end
        end
        default: begin
          next_cur.state  = stog_off;
          next_cur.enable = 1'b0;
        end
      endcase
    end
  end

  // Registers; reset comes up in the off state, drive removed
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cur       <= '0;
      cur.state <= stog_off;
      cur.sync_j1 <= 1'b1;
      cur.sync_j2 <= 1'b1;
    end else begin
      cur <= next_cur;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Combinational AND with synchronised inputs so a low input cuts without waiting for the enable register
  // Run state required too: enable left over from feature-off must not leak
  assign drive_enable      = cur.enable & (~active | (both_high & (cur.state == stog_run)));
  assign brake_request     = 1'b0;
  assign fault             = cur.fault & active;
  assign feature_active    = active;
  assign check_drive       = cur.pulse;
  // Ordinary inputs masked while reassigned to safety
  assign general_input_one = active ? 1'b0 : torque_off_input_a;
  assign general_input_two = active ? 1'b0 : torque_off_input_b;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_enable_needs_both;
    @(posedge clock) disable iff (!rstn)
      (active && drive_enable) |-> (torque_off_input_a && torque_off_input_b);
  endproperty
  a_enable_needs_both: assert property (p_enable_needs_both)
    else $error("drive enabled without both inputs high");

  property p_check_before_run;
    @(posedge clock) disable iff (!rstn)
      (cur.state == stog_run && $past(cur.state) != stog_run) |->
        $past(cur.state) == stog_check;
  endproperty
  a_check_before_run: assert property (p_check_before_run)
    else $error("run entered without self-check");

  property p_drive_needs_run;
    @(posedge clock) disable iff (!rstn)
      (active && drive_enable) |-> cur.state == stog_run;
  endproperty
  a_drive_needs_run: assert property (p_drive_needs_run)
    else $error("drive enabled outside run state");

  property p_entry_checks;
    @(posedge clock) disable iff (!rstn)
      (active && cur.state == stog_off && both_high && !cur.both_prev) |=>
        cur.state == stog_check;
  endproperty
  a_entry_checks: assert property (p_entry_checks)
    else $error("both-high entry did not start check");

  property p_low_cuts;
    @(posedge clock) disable iff (!rstn)
      (active && !both_high) |-> !drive_enable;
  endproperty
  a_low_cuts: assert property (p_low_cuts)
    else $error("drive kept with a low input");

  property p_mismatch_fault;
    @(posedge clock) disable iff (!rstn)
      (active && cur.state == stog_run && (torque_off_input_a ^ torque_off_input_b))
        |=> fault;
  endproperty
  a_mismatch_fault: assert property (p_mismatch_fault)
    else $error("input mismatch not flagged");

  property p_inactive_free;
    @(posedge clock) disable iff (!rstn)
      !active |=> !cur.fault;
  endproperty
  a_inactive_free: assert property (p_inactive_free)
    else $error("fault shown with feature off");

  property p_no_brake;
    @(posedge clock) disable iff (!rstn) !brake_request;
  endproperty
  a_no_brake: assert property (p_no_brake)
    else $error("active brake requested");

  property p_fail_holds;
    @(posedge clock) disable iff (!rstn)
      (active && cur.state == stog_failed) |-> (fault && !drive_enable);
  endproperty
  a_fail_holds: assert property (p_fail_holds)
    else $error("failed check not held");

  property p_masked_inputs;
    @(posedge clock) disable iff (!rstn)
      active |-> (!general_input_one && !general_input_two);
  endproperty
  a_masked_inputs: assert property (p_masked_inputs)
    else $error("general inputs leak while reassigned");

endmodule // stog_gate

/* sim/stog_loop.sv */
// Partner model: safety circuit loopback seen by the self-check
module stog_loop (
  // Self-check loop
  input  wire logic check_drive,
  output logic      check_readback,
  // Scenario control: loop broken on purpose
  input  wire logic broken
);
  timeunit 1ns;
  timeprecision 1ns;
  // Healthy loop echoes the pulse; a broken one inverts it
  assign check_readback = broken ? ~check_drive : check_drive;
endmodule // stog_loop

/* sim/tb_stog_gate.sv */
// Testbench of the safe torque off gate
module tb_stog_gate;
  import stog_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************
  // Signals
  // ****************
  logic clock = 0, rstn = 0, pin_a = 0, pin_b = 0, jumper = 1, broken = 0;
  logic chk_drv, chk_rb, drive, brake, fault, active, gen_a, gen_b;
  int   n_errors = 0, check_count = 0;
  // 25 MHz clock
  always #20 clock = ~clock;
  stog_gate uut (.clock(clock), .rstn(rstn), .digital_input_one(pin_a),
    .digital_input_two(pin_b), .jumper_fitted(jumper), .check_drive(chk_drv),
    .check_readback(chk_rb), .drive_enable(drive), .brake_request(brake),
    .fault(fault), .feature_active(active), .general_input_one(gen_a),
    .general_input_two(gen_b));
  stog_loop loop_model (.check_drive(chk_drv), .check_readback(chk_rb), .broken(broken));
  // ****************
  // Helpers
  // ****************
  task automatic chk(input string name, input logic seen, input logic exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %b seen %b", name, exp, seen);
    end
  endtask
  // Sample on falling edges, where outputs are settled
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic pins(input logic a, input logic b);
    @(posedge clock);
    pin_a <= a;
    pin_b <= b;
  endtask
  // Bounded wait for the drive to come up; n counts cycles
  task automatic wait_on(output int n);
    n = 0;
    while (drive !== 1'b1 && n < 300) begin
      cyc(1);
      n++;
    end
  endtask
  task automatic results();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic sc_feature_off();
    pins(1, 0);
    cyc(5);
    chk("drive", drive, 1'b1);
    chk("active", active, 1'b0);
    chk("gen_a", gen_a, 1'b1);
    chk("gen_b", gen_b, 1'b0);
    pins(0, 1);
    cyc(3);
    chk("gen_a", gen_a, 1'b0);
    chk("gen_b", gen_b, 1'b1);
    chk("fault", fault, 1'b0);
    // Leave both high so feature entry must still run a check
    pins(1, 1);
    cyc(3);
  endtask
  task automatic sc_feature_on();
    @(posedge clock);
    jumper <= 1'b0;
    cyc(5);
    chk("active", active, 1'b1);
    chk("gen_a", gen_a, 1'b0);
    chk("drive", drive, 1'b0);
    chk("check_drive", chk_drv, 1'b1);
    pins(1, 0);
    cyc(5);
    chk("fault", fault, 1'b1);
    pins(0, 0);
    cyc(5);
    chk("fault", fault, 1'b0);
    chk("drive", drive, 1'b0);
  endtask
  // Entry into both-high must run a full check first
  task automatic sc_check_pass();
    int n;
    pins(1, 1);
    cyc(20);
    chk("drive", drive, 1'b0);
    chk("check_drive", chk_drv, 1'b1);
    chk("gen_b", gen_b, 1'b0);
    wait_on(n);
    chk("drive", drive, 1'b1);
    chk("check_len", n >= 70, 1'b1);
    chk("fault", fault, 1'b0);
    chk("brake", brake, 1'b0);
  endtask
  // One input drops while running
  task automatic sc_drop(input logic a, input logic b);
    pins(a, b);
    cyc(3);
    chk("drive", drive, 1'b0);
    cyc(1);
    chk("fault", fault, 1'b1);
    chk("brake", brake, 1'b0);
    sc_check_pass();
  endtask
  task automatic sc_check_fail();
    @(posedge clock);
    broken <= 1'b1;
    pins(0, 0);
    cyc(4);
    pins(1, 1);
    cyc(200);
    chk("drive", drive, 1'b0);
    chk("fault", fault, 1'b1);
    @(posedge clock);
    broken <= 1'b0;
    pins(0, 0);
    cyc(4);
    sc_check_pass();
  endtask
  // ****************
  // Main sequence and watchdog
  // ****************
  initial begin
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    sc_feature_off();
    sc_feature_on();
    sc_check_pass();
    sc_drop(0, 1);
    sc_drop(1, 0);
    sc_check_fail();
    results();
  end
  // Whole run needs well under 2000 cycles
  initial begin
    #80000;
    n_errors++;
    results();
  end
endmodule // tb_stog_gate
